// ==== logic/msp_port.sv ====
// Slave register port of the host bus, mode 1 style.
// Assumes host bus pins arrive asynchronously and pass two flip-flops.
//
// Contract
// RQ1 - Reset input held active for at least ten bus clocks.
// RQ2 - Interrupt output stays inactive three clocks after release before reasserting.
// RQ3 - Master presents direction, address and size before asserting address strobe.
// RQ4 - Chip select sampled on a rising edge after address strobe goes active.
// RQ5 - Burst acknowledge driven inactive during slave accesses.
// RQ6 - Reads insert exactly two wait cycles before driving data.
// RQ7 - Normal cycle ends with slave acknowledge; faults assert bus error instead.
// RQ8 - Synchronous termination is sampled on a rising clock edge.
// RQ9 - Strobe withdrawal releases acknowledge, bus error and read data.
// RQ10 - Every address strobe is matched by a synchronous termination.
// RQ11 - Target register chosen by lowest seven address bits.
// RQ12 - Without chip select, data, acknowledge and bus error stay undriven.
module msp_port (
  // Clock and reset.
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Host bus inputs.
  input  wire logic        addr_strobe_n_in,
  input  wire logic        chip_sel_n_in,
  input  wire logic        rd_wr_n_in,
  input  wire logic [6:0]  addr_in,
  input  wire logic [1:0]  xfer_size_in,
  input  wire logic [31:0] data_in,
  input  wire logic        sync_termination_n_in,
  // Host bus outputs with enables, enable low while driving.
  output logic [31:0]      data_out,
  output logic             data_oe_n_out,
  output logic             slave_ack_n_out,
  output logic             slave_ack_oe_n_out,
  output logic             bus_fault_n_out,
  output logic             bus_fault_oe_n_out,
  output logic             burst_ack_n_out,
  output logic             burst_ack_oe_n_out,
  // Interrupt.
  input  wire logic        irq_req_in,
  output logic             irq_n_out,
  // Status.
  output logic             term_seen_out
);
  msp_reg_if rif ();
  msp_regs #(.NREGS(32)) u_regs (.clk_in(core_clk_in), .rst_in(rst_in), .bus(rif));

  // Two-stage synchronisers for all host bus pins.
  logic [44:0] s1_r;
  logic [44:0] s2_r;
  always_ff @(posedge core_clk_in) begin
    s1_r <= {addr_strobe_n_in, chip_sel_n_in, rd_wr_n_in, addr_in, xfer_size_in, data_in, sync_termination_n_in};
    s2_r <= s1_r;
  end
  logic        as_n;
  logic        cs_n;
  logic        rd;
  logic [6:0]  addr;
  logic [31:0] wdat;
  logic        term_n;
  assign as_n   = s2_r[44];
  assign cs_n   = s2_r[43];
  assign rd     = s2_r[42];
  assign addr   = s2_r[41:35];
  assign wdat   = s2_r[32:1];
  assign term_n = s2_r[0];

  msp_pkg::msp_state_e st_r, st_nxt;
  logic [1:0]  wait_r, wait_nxt;
  logic        rd_r, rd_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic [31:0] dout_r, dout_nxt;
  logic        ack_r, ack_nxt;
  logic        flt_r, flt_nxt;
  logic        term_r, term_nxt;

  assign rif.addr  = addr_r; // RQ11
  assign rif.wdata = wdat;
  assign rif.rd_en = (st_r == msp_pkg::MSP_WAIT) && rd_r;

  always_comb begin
    st_nxt      = st_r;
    wait_nxt    = wait_r;
    rd_nxt      = rd_r;
    addr_nxt    = addr_r;
    dout_nxt    = dout_r;
    ack_nxt     = ack_r;
    flt_nxt     = flt_r;
    term_nxt    = term_r;
    rif.wr_en   = 1'b0;
    case (st_r)
      msp_pkg::MSP_IDLE: begin
        if (!as_n) begin
          // Direction, address and size already stable before strobe.
          rd_nxt   = rd; // RQ3
          addr_nxt = addr;
          st_nxt   = msp_pkg::MSP_SAMPLE;
        end
      end
      msp_pkg::MSP_SAMPLE: begin
        // Chip select sampled on an edge after the strobe.
        if (as_n) begin
          st_nxt = msp_pkg::MSP_IDLE;
        end else if (!cs_n && !rd_r) begin // RQ4
          // Writes carry no wait state and close at once.
          rif.wr_en = 1'b1;
          ack_nxt   = !rif.fault; // RQ7
          flt_nxt   = rif.fault; // RQ7
          st_nxt    = msp_pkg::MSP_ACK;
        end else if (!cs_n) begin // RQ4
          wait_nxt = 2'h0;
          st_nxt   = msp_pkg::MSP_WAIT;
        end else begin
          st_nxt = msp_pkg::MSP_FOREIGN; // RQ12
        end
      end
      msp_pkg::MSP_WAIT: begin
        if (as_n) begin
          st_nxt = msp_pkg::MSP_IDLE;
        end else if (wait_r == 2'(msp_pkg::READ_WAIT_CYC - 1)) begin // RQ6
          dout_nxt  = rif.rdata;
          ack_nxt   = !rif.fault; // RQ7
          flt_nxt   = rif.fault; // RQ7
          st_nxt    = msp_pkg::MSP_ACK;
        end else begin
          wait_nxt = wait_r + 2'h1;
        end
      end
      msp_pkg::MSP_ACK: begin
        if (!term_n) begin
          term_nxt = 1'b1; // RQ8
        end
        if (as_n) begin
          ack_nxt = 1'b0; // RQ9
          flt_nxt = 1'b0;
          st_nxt  = msp_pkg::MSP_IDLE;
        end
      end
      default: begin
        if (as_n) begin
          st_nxt = msp_pkg::MSP_IDLE;
        end
      end
    endcase
    if (st_r == msp_pkg::MSP_IDLE && !as_n) begin
      term_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r   <= msp_pkg::MSP_IDLE;
      wait_r <= 2'h0;
      rd_r   <= 1'b0;
      addr_r <= 7'h00;
      dout_r <= 32'h0000_0000;
      ack_r  <= 1'b0;
      flt_r  <= 1'b0;
      term_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      wait_r <= wait_nxt;
      rd_r   <= rd_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      ack_r  <= ack_nxt;
      flt_r  <= flt_nxt;
      term_r <= term_nxt;
    end
  end

  logic in_cycle;
  assign in_cycle           = (st_r == msp_pkg::MSP_WAIT) || (st_r == msp_pkg::MSP_ACK);
  assign data_out           = dout_r;
  assign data_oe_n_out      = !((st_r == msp_pkg::MSP_ACK) && rd_r); // RQ9
  assign slave_ack_n_out    = !ack_r;
  assign slave_ack_oe_n_out = !in_cycle; // RQ12
  assign bus_fault_n_out    = !flt_r;
  assign bus_fault_oe_n_out = !in_cycle;
  assign burst_ack_n_out    = 1'b1; // RQ5
  assign burst_ack_oe_n_out = !in_cycle;
  assign term_seen_out      = term_r;

  // Interrupt output with enforced idle time after release.
  logic       irq_r, irq_nxt;
  logic [1:0] idle_r, idle_nxt;
  always_comb begin
    irq_nxt  = irq_r;
    idle_nxt = idle_r;
    if (irq_r) begin
      if (!irq_req_in) begin
        irq_nxt  = 1'b0;
        idle_nxt = 2'(msp_pkg::IRQ_IDLE_BCLK);
      end
    end else if (idle_r != 2'h0) begin
      idle_nxt = idle_r - 2'h1; // RQ2
    end else if (irq_req_in) begin
      irq_nxt = 1'b1;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_r  <= 1'b0;
      idle_r <= 2'h0;
    end else begin
      irq_r  <= irq_nxt;
      idle_r <= idle_nxt;
    end
  end
  assign irq_n_out = !irq_r;

  a_irq_idle_gap: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(irq_r) |=> !irq_r [*3]) else $error("interrupt reasserted too soon"); // RQ2
  a_read_two_waits: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r == msp_pkg::MSP_SAMPLE && !cs_n && !as_n && rd_r) |=> (st_r == msp_pkg::MSP_WAIT) [*2] ##1
    (st_r == msp_pkg::MSP_ACK || as_n)) else $error("read wait count wrong"); // RQ6
  a_burst_inactive: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !burst_ack_oe_n_out |-> burst_ack_n_out) else $error("burst ack driven active"); // RQ5
  a_ack_excl: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !(ack_r && flt_r)) else $error("ack and fault together"); // RQ7
  a_release_strobe: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r == msp_pkg::MSP_ACK && as_n) |=> (slave_ack_oe_n_out && data_oe_n_out && !ack_r))
    else $error("not released after strobe"); // RQ9
  a_foreign_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r == msp_pkg::MSP_FOREIGN) |-> (slave_ack_oe_n_out && bus_fault_oe_n_out && data_oe_n_out))
    else $error("drove lines in foreign cycle"); // RQ12
  a_cs_sample: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r == msp_pkg::MSP_SAMPLE && !as_n && cs_n) |=> st_r == msp_pkg::MSP_FOREIGN)
    else $error("chip select ignored"); // RQ4
  a_term_sample: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st_r == msp_pkg::MSP_ACK && !term_n) |=> term_r) else $error("termination not captured"); // RQ8
endmodule : msp_port

// ==== logic/msp_pkg.sv ====
// Package with constants for the slave register port.
// Assumes a single host bus clock domain at 25 MHz.
package msp_pkg;
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          RST_PULSE_BCLK = 10;
  localparam int          IRQ_IDLE_BCLK  = 3;
  localparam int          READ_WAIT_CYC  = 2;
  localparam int          REG_ADDR_W     = 7;
  localparam int          DATA_W         = 32;
  localparam logic [1:0]  SIZE_LONG      = 2'h0;
  localparam logic [31:0] REG_RESET_VAL  = 32'h0000_0000;
  localparam logic [3:0]  STAT_IDX       = 4'h0;
  typedef enum logic [2:0] {MSP_IDLE, MSP_SAMPLE, MSP_WAIT, MSP_ACK, MSP_FOREIGN} msp_state_e;
endpackage : msp_pkg

// ==== logic/msp_if.sv ====
// Interface between the port controller and its register array.
// Assumes both ends share the host bus clock.
interface msp_reg_if;
  logic                                rd_en;
  logic                                wr_en;
  logic [msp_pkg::REG_ADDR_W-1:0]      addr;
  logic [msp_pkg::DATA_W-1:0]          wdata;
  logic [msp_pkg::DATA_W-1:0]          rdata;
  logic                                fault;
  modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata, input fault);
  modport regs (input rd_en, input wr_en, input addr, input wdata, output rdata, output fault);
endinterface : msp_reg_if

// ==== logic/msp_regs.sv ====
// Register array reached through the slave port.
// Assumes addresses arrive already latched by the controller.
module msp_regs #(
  parameter int NREGS = 32
) (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Controller side.
  msp_reg_if.regs   bus
);
  logic [msp_pkg::DATA_W-1:0] mem_r [NREGS];
  logic [msp_pkg::DATA_W-1:0] mem_nxt [NREGS];
  logic [4:0]                 idx;

  assign idx = bus.addr[6:2];

  // Word index from the low seven address bits; beyond the array is a fault.
  assign bus.fault = (int'(idx) >= NREGS); // RQ11
  assign bus.rdata = bus.fault ? '0 : mem_r[idx];

  always_comb begin
    for (int i = 0; i < NREGS; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (bus.wr_en && !bus.fault) begin
      mem_nxt[idx] = bus.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NREGS; i++) begin
      mem_r[i] <= rst_in ? msp_pkg::REG_RESET_VAL : mem_nxt[i];
    end
  end
endmodule : msp_regs

// ==== test/msp_host_model.sv ====
// Host bus master model that opens slave cycles on the port.
// Assumes the bench calls xfer after reset, one call at a time.
module msp_host_model (
  // Clock.
  input  wire logic        clk_in,
  // Pins toward the port.
  output logic             as_n_out,
  output logic             cs_n_out,
  output logic             rw_out,
  output logic [6:0]       addr_out,
  output logic [1:0]       size_out,
  output logic [31:0]      wd_out,
  output logic             term_n_out,
  // Pins from the port.
  input  wire logic [31:0] rd_in,
  input  wire logic        rd_oe_n_in,
  input  wire logic        ack_n_in,
  input  wire logic        ack_oe_n_in,
  input  wire logic        flt_n_in,
  input  wire logic        flt_oe_n_in,
  input  wire logic        bst_n_in,
  input  wire logic        bst_oe_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    as_n_out   = 1'b1;
    cs_n_out   = 1'b1;
    rw_out     = 1'b1;
    addr_out   = 7'h55;
    size_out   = msp_pkg::SIZE_LONG;
    wd_out     = 32'h0;
    term_n_out = 1'b1;
  end
  // Runs one cycle; a foreign cycle is held eight clocks, then terminated.
  task xfer(input logic rd, input logic sel, input logic [6:0] a, input logic [31:0] wd,
            input int slow, output logic [31:0] q, output int lat, output int rel, output logic good);
    lat = 0;
    rel = 0;
    good = 1'b1;
    @(posedge clk_in);
    rw_out <= rd;
    cs_n_out <= ~sel;
    addr_out <= a;
    wd_out <= wd;
    @(posedge clk_in);
    as_n_out <= 1'b0;
    do begin
      @(posedge clk_in);
      lat++;
      if (!sel && (ack_oe_n_in !== 1'b1 || rd_oe_n_in !== 1'b1 || flt_oe_n_in !== 1'b1)) good = 1'b0;
    end while (lat < 12 && (sel ? (ack_oe_n_in !== 1'b0 || ack_n_in !== 1'b0) : lat < 8));
    q = rd_in;
    if (sel && (lat == 12 || bst_n_in !== 1'b1 || bst_oe_n_in !== 1'b0 || flt_n_in !== 1'b1)) good = 1'b0;
    if (sel && rd && rd_oe_n_in !== 1'b0) good = 1'b0;
    repeat (slow) @(posedge clk_in);
    if (sel && ack_oe_n_in !== 1'b0) good = 1'b0;
    term_n_out <= 1'b0;
    @(posedge clk_in);
    as_n_out <= 1'b1;
    term_n_out <= 1'b1;
    cs_n_out <= 1'b1;
    rw_out <= ~rd;
    addr_out <= ~a;
    wd_out <= ~wd;
    do begin
      @(posedge clk_in);
      rel++;
    end while (rel < 12 && (ack_oe_n_in !== 1'b1 || rd_oe_n_in !== 1'b1 || flt_oe_n_in !== 1'b1));
    repeat (3) @(posedge clk_in);
  endtask : xfer
endmodule : msp_host_model

// ==== test/msp_port_bench.sv ====
// Self-checking bench for the slave register port with a host model.
// Assumes one 25 MHz clock and a synchronous active-high reset.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module msp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        irq_req_in  = 1'b0;
  logic        as_n, cs_n, rw, term_n, d_oe_n, ack_n, ack_oe_n, flt_n, flt_oe_n, bst_n, bst_oe_n;
  logic        irq_n_out, term_seen_out;
  logic [6:0]  addr;
  logic [1:0]  size;
  logic [31:0] wd, rd;
  logic [31:0] regs [32];
  int          seed = 32'hb43d;
  int          mismatches = 0;
  int          num_checks = 0;
  int          irq_hi = 0;
  int          wr_lat = 0;
  msp_port i_msp_port (.core_clk_in(core_clk_in), .rst_in(rst_in), .addr_strobe_n_in(as_n),
    .chip_sel_n_in(cs_n), .rd_wr_n_in(rw), .addr_in(addr), .xfer_size_in(size), .data_in(wd),
    .sync_termination_n_in(term_n), .data_out(rd), .data_oe_n_out(d_oe_n), .slave_ack_n_out(ack_n),
    .slave_ack_oe_n_out(ack_oe_n), .bus_fault_n_out(flt_n), .bus_fault_oe_n_out(flt_oe_n),
    .burst_ack_n_out(bst_n), .burst_ack_oe_n_out(bst_oe_n), .irq_req_in(irq_req_in),
    .irq_n_out(irq_n_out), .term_seen_out(term_seen_out));
  msp_host_model i_msp_host_model (.clk_in(core_clk_in), .as_n_out(as_n), .cs_n_out(cs_n),
    .rw_out(rw), .addr_out(addr), .size_out(size), .wd_out(wd), .term_n_out(term_n), .rd_in(rd),
    .rd_oe_n_in(d_oe_n), .ack_n_in(ack_n), .ack_oe_n_in(ack_oe_n), .flt_n_in(flt_n),
    .flt_oe_n_in(flt_oe_n), .bst_n_in(bst_n), .bst_oe_n_in(bst_oe_n));
  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    irq_req_in <= ^$random(seed);
    if (irq_n_out === 1'b1) irq_hi <= irq_hi + 1;
    else begin
      if (irq_hi != 0 && !rst_in) `CHK("irq idle", 1'b1, irq_hi >= msp_pkg::IRQ_IDLE_BCLK)
      irq_hi <= 0;
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // One host cycle; a selected write updates the bench's copy, a selected read compares against it.
  task automatic run(input logic rd_c, input logic sel, input logic [6:0] a, input logic [31:0] d, input int slow);
    logic [31:0] q;
    int          lat, rel;
    logic        good;
    i_msp_host_model.xfer(rd_c, sel, a, d, slow, q, lat, rel, good);
    `CHK("clean cycle", 1'b1, good)
    `CHK("release", 1'b1, rel <= 5)
    if (sel) begin
      `CHK("term seen", 1'b1, term_seen_out)
      if (rd_c) begin
        `CHK("read data", regs[a[6:2]], q)
        `CHK("read wait", wr_lat + msp_pkg::READ_WAIT_CYC, lat)
      end else begin
        regs[a[6:2]] = d;
        wr_lat = lat;
      end
    end
  endtask : run
  initial begin
    logic [6:0] a;
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    run(1'b0, 1'b1, 7'h7f, 32'ha5a5_0f0f, 0);
    run(1'b0, 1'b1, 7'h04, 32'h1234_5678, 2);
    run(1'b1, 1'b0, 7'h7c, 32'h0, 0);
    run(1'b1, 1'b1, 7'h7c, 32'h0, 3);
    run(1'b1, 1'b1, 7'h07, 32'h0, 0);
    $display("corner cycles done");
    repeat (12) begin
      a = 7'($random(seed));
      if (a[6:2] == 5'h0) a[6:2] = 5'h1f;
      run(1'b0, 1'b1, a, $random(seed), $random(seed) & 3);
      run(^$random(seed), 1'b0, a, $random(seed), 0);
      run(1'b1, 1'b1, a ^ 7'($random(seed) & 3), 32'h0, $random(seed) & 3);
    end
    $display("random cycles done");
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    mismatches++;
    complete_run;
  end
endmodule : msp_port_bench
